// ==== bench/mhs_carrier_model.sv ====
// Far-side model: payload supply and the boot code image.
// Assumes one clock; bad skews the image so its sum is no longer zero.
`timescale 1ns/1ns
module mhs_carrier_model (
  input wire logic pclk, // System clock
  input wire logic por_n, // Power-on reset, low
  input wire logic payload_power_en, // Supply enable
  input wire logic [3:0] code_addr, // Image address
  input wire logic bad, // Corrupt last word
  output logic payload_pgood, // Supply good
  output logic [31:0] code_data // Image word
);
  logic [2:0] ramp_ff;
  // Supply settles three cycles late either way, so the design must wait
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      ramp_ff <= 3'h0;
    end else begin
      ramp_ff <= {ramp_ff[1:0], payload_power_en};
    end
  end
  assign payload_pgood = ramp_ff[2];
  // Words 0..14 sum to 32'h348, the last word cancels it
  always_ff @(posedge pclk) begin
    code_data <= (code_addr == 4'hF) ? 32'hFFFFFCB8 + {31'h0, bad} : {25'h0, code_addr, 3'h0};
  end
endmodule // mhs_carrier_model

// ==== bench/testbench.sv ====
// Self-checking bench for the hot-swap and LED manager.
// Assumes the far-side model supplies payload power good and the code image.
`timescale 1ns/1ns
module testbench;
  logic pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, w, e, bad;
  logic handle_switch_n, module_seated_n, payload_pgood, selftest_done, selftest_pass;
  logic fit_report, wdog_strobe, handle_open_evt, quiesced_evt, payload_power_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, code_data, r, n;
  logic [7:0] c;
  logic [3:0] code_addr;
  mhs_pkg::mhs_led_type leds;
  int err_total, checks, cyc;
  localparam int Q = 25;
  // Fast share truncates within each quarter, so it may fall just short of half
  localparam logic [31:0] FAST_SUM =
    32'(mhs_pkg::BLINK_QUARTERS * (Q * mhs_pkg::FAST_ON_PCT / mhs_pkg::PCT_FULL));
  mhs_manager #(.BLINK_QUARTER(Q), .WDOG_CYC(20)) dut (.pclk, .presetn, .por_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .handle_switch_n, .module_seated_n, .payload_pgood, .selftest_done,
    .selftest_pass, .code_addr, .code_data, .fit_report, .wdog_strobe,
    .handle_open_evt, .quiesced_evt, .payload_power_en, .leds);
  mhs_carrier_model model (.pclk, .por_n, .payload_power_en, .code_addr, .bad,
    .payload_pgood, .code_data);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sampled 1 ns after the edge so register updates have landed
  task automatic duty(input int b, input logic [31:0] exp);
    n = '0;
    repeat (100) begin
      @(posedge pclk);
      #1 n = n + leds[b];
    end
    chk(n, exp);
  endtask
  task automatic await(ref logic s);
    for (int i = 0; i < 300 && s !== 1'b1; i++) begin
      @(posedge pclk);
      #1;
    end
  endtask
  task automatic st(input logic [9:0] x);
    apb(1'b0, mhs_pkg::STATUS_OFS, '0);
    chk(r[9:0], x);
  endtask
  task automatic cmd(input int b);
    apb(1'b1, mhs_pkg::CMD_OFS, 32'h1 << b);
    repeat (2) @(posedge pclk);
  endtask
  task automatic reopen();
    @(posedge pclk);
    handle_switch_n <= 1'b1;
    repeat (8) @(posedge pclk);
    handle_switch_n <= 1'b0;
    await(handle_open_evt);
    chk(handle_open_evt, 1'b1);
    repeat (3) @(posedge pclk);
  endtask
  task automatic restart(input logic b, input logic pe);
    @(posedge pclk);
    bad <= b;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    #1 chk(leds.red, 1'b1);
    chk(payload_power_en, pe);
    @(posedge pclk);
    presetn <= 1'b1;
  endtask
  function automatic logic [31:0] red_exp(input logic [7:0] v);
    if (v[0]) begin
      return v[1] ? 32'h64 : 32'h0;
    end
    return v[4] ? FAST_SUM : (v[5] ? 32'hA : 32'h0);
  endfunction
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h87F3));
    {presetn, por_n, psel, penable, pwrite, bad} <= '0;
    {handle_switch_n, module_seated_n, selftest_done, selftest_pass} <= 4'hB;
    paddr <= '0;
    pwdata <= '0;
    repeat (10) @(posedge pclk);
    #1 chk({leds.red, leds.blue, payload_power_en}, 3'h4);
    @(posedge pclk);
    {presetn, por_n} <= 2'h3;
    await(fit_report);
    chk(fit_report, 1'b1);
    repeat (5) @(posedge pclk);
    st(10'h031);
    duty(3, 32'h5A);
    n = '0;
    w = wdog_strobe;
    repeat (100) begin
      @(posedge pclk);
      #1 n = n + (wdog_strobe !== w);
      w = wdog_strobe;
    end
    chk(n, 32'h5);
    cmd(mhs_pkg::CMD_ACTIVATE);
    repeat (10) @(posedge pclk);
    st(10'h133);
    duty(3, 32'h0);
    chk({leds.green, leds.amber}, 2'h2);
    restart(1'b0, 1'b1);
    await(fit_report);
    repeat (5) @(posedge pclk);
    st(10'h133);
    reopen();
    st(10'h334);
    duty(3, 32'hA);
    @(posedge pclk);
    handle_switch_n <= 1'b1;
    repeat (8) @(posedge pclk);
    st(10'h133);
    reopen();
    cmd(mhs_pkg::CMD_REJECT);
    st(10'h333);
    duty(3, 32'h0);
    reopen();
    cmd(mhs_pkg::CMD_QUIESCE);
    await(quiesced_evt);
    chk({quiesced_evt, payload_power_en}, 2'h2);
    repeat (5) @(posedge pclk);
    st(10'h230);
    apb(1'b0, mhs_pkg::EVT_OFS, '0);
    chk(r, 32'h3);
    apb(1'b1, mhs_pkg::EVT_OFS, 32'h3);
    apb(1'b0, mhs_pkg::EVT_OFS, '0);
    chk(r, 32'h0);
    duty(3, 32'h64);
    chk({leds.green, leds.amber}, 2'h1);
    for (int i = 0; i < 6; i++) begin
      c = (i < 3) ? {2'h0, i[1:0] + 2'h1, 4'h0} : 8'($urandom);
      apb(1'b1, mhs_pkg::CTRL_OFS, {24'h0, c});
      apb(1'b0, mhs_pkg::CTRL_OFS, '0);
      chk(r, {24'h0, c});
      duty(2, red_exp(c));
      chk({leds.green, leds.amber}, c[2] ? {~c[3], c[3]} : 2'h1);
    end
    apb(1'b0, 12'h010, '0);
    chk({r[30:0], e}, 32'h1);
    restart(1'b1, 1'b0);
    repeat (60) @(posedge pclk);
    st(10'h240);
    conclude();
  end
endmodule // testbench

// ==== rtl/mhs_blink.sv ====
// Duty-cycle pattern generator driven by the shared period counter.
// Assumes qidx and qcnt come from one free-running quarter counter.
`timescale 1ns/1ns
module mhs_blink #(
  parameter int QUARTER = mhs_pkg::BLINK_QUARTER_CYC
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, low
  input wire logic reset_lit, // Reset level, ignored; lit resets low
  input wire logic [1:0] qidx, // Quarter index of period
  input wire logic [mhs_pkg::CNT_W-1:0] qcnt, // Count within quarter
  input wire mhs_pkg::mhs_pattern_type pattern, // Pattern to show
  output logic lit // LED drive
);
  localparam longint PERIOD = longint'(QUARTER) * mhs_pkg::BLINK_QUARTERS;
  localparam logic [31:0] LONG_ON = 32'(PERIOD * mhs_pkg::LONG_ON_PCT / mhs_pkg::PCT_FULL);
  localparam logic [31:0] SHORT_ON = 32'(PERIOD * mhs_pkg::SHORT_ON_PCT / mhs_pkg::PCT_FULL);
  localparam logic [31:0] FAST_ON =
    32'(longint'(QUARTER) * mhs_pkg::FAST_ON_PCT / mhs_pkg::PCT_FULL);

  logic [31:0] pos;
  logic nxt_lit;

  assign pos = 32'(qidx) * 32'(QUARTER) + qcnt;

  always_comb begin
    case (pattern)
      mhs_pkg::pat_on: nxt_lit = 1'b1;
      mhs_pkg::pat_long: nxt_lit = pos < LONG_ON;
      mhs_pkg::pat_short: nxt_lit = pos < SHORT_ON;
      mhs_pkg::pat_fast: nxt_lit = qcnt < FAST_ON;
      default: nxt_lit = 1'b0;
    endcase
  end

  // Reset level port is ignored; lit resets low and the manager holds red lit through reset instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lit <= 1'b0;
    else lit <= nxt_lit | (reset_lit & 1'b0);
  end

  long_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    pattern == mhs_pkg::pat_long && pos >= LONG_ON |=> !lit)
    else $error("long blink lit past its share");
  short_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    pattern == mhs_pkg::pat_short |=> lit == $past(pos < SHORT_ON))
    else $error("short blink share wrong");
  fast_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
    pattern == mhs_pkg::pat_fast && qcnt >= FAST_ON |=> !lit)
    else $error("fast blink lit past half");
endmodule // mhs_blink

// ==== rtl/mhs_manager.sv ====
// Hot-swap, boot sequencer and front-panel LED manager with APB registers.
// Assumes carrier commands arrive as APB writes from controller firmware,
// and that por_n is the board power-on reset, untouched by watchdog restarts.
`timescale 1ns/1ns
module mhs_manager #(
  parameter int BLINK_QUARTER = mhs_pkg::BLINK_QUARTER_CYC, // Quarter blink period
  parameter int WDOG_CYC = mhs_pkg::WDOG_INTERVAL_CYC // Watchdog strobe spacing
) (
  input wire logic pclk, // 100 MHz clock
  input wire logic presetn, // Controller reset, low
  input wire logic por_n, // Board power-on reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [mhs_pkg::ADDR_W-1:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic handle_switch_n, // Handle switch pin, low open
  input wire logic module_seated_n, // Seated pin, low seated
  input wire logic payload_pgood, // Payload power good pin
  input wire logic selftest_done, // Self-test finished
  input wire logic selftest_pass, // Self-test result
  output logic [mhs_pkg::CODE_AW-1:0] code_addr, // Code image address
  input wire logic [31:0] code_data, // Code word, one cycle later
  output logic fit_report, // Fitness pulse to update_supervisor
  output logic wdog_strobe, // Watchdog strobe to update_supervisor
  output logic handle_open_evt, // Handle-open event pulse
  output logic quiesced_evt, // Quiesced event pulse
  output logic payload_power_en, // Payload power enable
  output mhs_pkg::mhs_led_type leds // Front-panel LEDs
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [2:0] pins_sync;
  logic handle_open, seated, pgood;

  mhs_sync #(.WIDTH(3)) u_sync (
    .pclk(pclk),
    .presetn(por_n),
    .async_in({~handle_switch_n, ~module_seated_n, payload_pgood}),
    .sync_out(pins_sync)
  );
  assign {handle_open, seated, pgood} = pins_sync;

  // ************************************************************
  // APB slave
  // ************************************************************
  mhs_pkg::mhs_ctrl_type ctrl_ff;
  logic [mhs_pkg::CMD_W-1:0] cmd_ff;
  logic [mhs_pkg::EVT_W-1:0] evt_ff;
  logic [31:0] prdata_ff;
  logic [31:0] status;
  logic mapped, wr_acc;
  mhs_pkg::mhs_hs_type hs_ff;
  mhs_pkg::mhs_boot_type boot_ff;

  always_comb begin
    if (paddr == mhs_pkg::CTRL_OFS) mapped = 1'b1;
    else if (paddr == mhs_pkg::CMD_OFS) mapped = 1'b1;
    else if (paddr == mhs_pkg::STATUS_OFS) mapped = 1'b1;
    else if (paddr == mhs_pkg::EVT_OFS) mapped = 1'b1;
    else mapped = 1'b0;
  end

  // Zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_ff;
  assign wr_acc = psel & penable & pwrite;

  always_comb begin
    status = '0;
    status[mhs_pkg::STS_HS_LSB +: 3] = hs_ff;
    status[mhs_pkg::STS_BOOT_LSB +: 3] = boot_ff;
    status[mhs_pkg::STS_PAYLOAD] = payload_power_en;
    status[mhs_pkg::STS_HANDLE_OPEN] = handle_open;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= '0;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == mhs_pkg::CTRL_OFS) prdata_ff <= 32'(ctrl_ff);
      else if (paddr == mhs_pkg::STATUS_OFS) prdata_ff <= status;
      else if (paddr == mhs_pkg::EVT_OFS) prdata_ff <= 32'(evt_ff);
      else prdata_ff <= '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ctrl_ff <= mhs_pkg::CTRL_RESET;
    else if (wr_acc && paddr == mhs_pkg::CTRL_OFS) ctrl_ff <= pwdata[mhs_pkg::CTRL_W-1:0];
  end

  // Commands are one-cycle pulses; the request states take them whatever the boot state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmd_ff <= '0;
    else if (wr_acc && paddr == mhs_pkg::CMD_OFS) cmd_ff <= pwdata[mhs_pkg::CMD_W-1:0];
    else cmd_ff <= '0;
  end

  // Sticky event copies, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_ff <= '0;
    end else begin
      evt_ff <= (evt_ff & ~((wr_acc && paddr == mhs_pkg::EVT_OFS) ?
        pwdata[mhs_pkg::EVT_W-1:0] : '0)) | {quiesced_evt, handle_open_evt};
    end
  end

  // ************************************************************
  // Boot sequencer
  // ************************************************************
  logic [mhs_pkg::CODE_AW:0] ck_idx_ff;
  logic ck_vld_ff;
  logic [31:0] sum_ff;
  logic boot_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_ff <= mhs_pkg::boot_selftest;
      ck_idx_ff <= '0;
      ck_vld_ff <= 1'b0;
      sum_ff <= '0;
      fit_report <= 1'b0;
    end else begin
      fit_report <= 1'b0;
      case (boot_ff)
        mhs_pkg::boot_selftest: begin
          if (selftest_done) begin
            boot_ff <= selftest_pass ? mhs_pkg::boot_checksum : mhs_pkg::boot_halt;
          end
        end
        mhs_pkg::boot_checksum: begin
          ck_vld_ff <= ck_idx_ff < (mhs_pkg::CODE_AW + 1)'(mhs_pkg::CODE_WORDS);
          if (ck_idx_ff < (mhs_pkg::CODE_AW + 1)'(mhs_pkg::CODE_WORDS)) begin
            ck_idx_ff <= ck_idx_ff + 1'b1;
          end
          if (ck_vld_ff) sum_ff <= sum_ff + code_data;
          if (ck_idx_ff == (mhs_pkg::CODE_AW + 1)'(mhs_pkg::CODE_WORDS) && !ck_vld_ff) begin
            boot_ff <= (sum_ff == mhs_pkg::SUM_GOOD) ? mhs_pkg::boot_report :
              mhs_pkg::boot_halt;
          end
        end
        mhs_pkg::boot_report: begin
          fit_report <= 1'b1;
          boot_ff <= mhs_pkg::boot_run;
        end
        default: boot_ff <= boot_ff;
      endcase
    end
  end

  assign code_addr = ck_idx_ff[mhs_pkg::CODE_AW-1:0];
  assign boot_ok = boot_ff == mhs_pkg::boot_run;

  // ************************************************************
  // Watchdog strobe
  // ************************************************************
  logic [mhs_pkg::CNT_W-1:0] wdog_cnt_ff;

  // Stops when operational code is not running, so the supervisor restarts us
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdog_cnt_ff <= '0;
      wdog_strobe <= 1'b0;
    end else if (boot_ok) begin
      if (wdog_cnt_ff == 32'(WDOG_CYC - 1)) begin
        wdog_cnt_ff <= '0;
        wdog_strobe <= ~wdog_strobe;
      end else begin
        wdog_cnt_ff <= wdog_cnt_ff + 1'b1;
      end
    end
  end

  // ************************************************************
  // Hot-swap state, kept across controller restarts
  // ************************************************************
  logic open_prev_ff;
  logic open_edge;

  assign open_edge = handle_open & ~open_prev_ff;

  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) open_prev_ff <= 1'b0;
    else open_prev_ff <= handle_open;
  end

  // Power and state sit on por_n so a watchdog restart leaves payload alone
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      hs_ff <= mhs_pkg::state_inactive;
      payload_power_en <= 1'b0;
      handle_open_evt <= 1'b0;
      quiesced_evt <= 1'b0;
    end else begin
      handle_open_evt <= 1'b0;
      quiesced_evt <= 1'b0;
      case (hs_ff)
        mhs_pkg::state_inactive: begin
          if (boot_ok && seated && !handle_open) hs_ff <= mhs_pkg::state_activation_request;
        end
        mhs_pkg::state_activation_request: begin
          if (handle_open) hs_ff <= mhs_pkg::state_inactive;
          else if (cmd_ff[mhs_pkg::CMD_ACTIVATE]) hs_ff <= mhs_pkg::state_activation_progress;
        end
        mhs_pkg::state_activation_progress: begin
          payload_power_en <= 1'b1;
          if (pgood) hs_ff <= mhs_pkg::state_active;
        end
        mhs_pkg::state_active: begin
          if (boot_ok && open_edge) begin
            hs_ff <= mhs_pkg::state_deactivation_request;
            handle_open_evt <= 1'b1;
          end
        end
        mhs_pkg::state_deactivation_request: begin
          // Repeated openings here raise nothing new
          if (cmd_ff[mhs_pkg::CMD_REJECT] || !handle_open) begin
            hs_ff <= mhs_pkg::state_active;
          end else if (cmd_ff[mhs_pkg::CMD_QUIESCE]) begin
            hs_ff <= mhs_pkg::state_deactivation_progress;
          end
        end
        mhs_pkg::state_deactivation_progress: begin
          payload_power_en <= 1'b0;
          if (!payload_power_en && !pgood) begin
            quiesced_evt <= 1'b1;
            hs_ff <= mhs_pkg::state_inactive;
          end
        end
        default: hs_ff <= mhs_pkg::state_inactive;
      endcase
    end
  end

  // ************************************************************
  // LEDs
  // ************************************************************
  logic [mhs_pkg::CNT_W-1:0] qcnt_ff;
  logic [1:0] qidx_ff;
  mhs_pkg::mhs_pattern_type blue_pat, red_pat;
  logic blue_lit, red_lit, red_up_ff, amber;

  // One counter paces every pattern, so blue and red blink in step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt_ff <= '0;
      qidx_ff <= '0;
    end else if (qcnt_ff == 32'(BLINK_QUARTER - 1)) begin
      qcnt_ff <= '0;
      qidx_ff <= qidx_ff + 1'b1;
    end else begin
      qcnt_ff <= qcnt_ff + 1'b1;
    end
  end

  always_comb begin
    case (hs_ff)
      mhs_pkg::state_inactive: blue_pat = mhs_pkg::pat_on;
      mhs_pkg::state_activation_request: blue_pat = mhs_pkg::pat_long;
      mhs_pkg::state_activation_progress: blue_pat = mhs_pkg::pat_long;
      mhs_pkg::state_active: blue_pat = mhs_pkg::pat_off;
      default: blue_pat = mhs_pkg::pat_short;
    endcase
    if (ctrl_ff.upgrade_active) red_pat = mhs_pkg::pat_fast;
    else if (ctrl_ff.power_denied) red_pat = mhs_pkg::pat_short;
    else red_pat = mhs_pkg::pat_off;
  end

  mhs_blink #(.QUARTER(BLINK_QUARTER)) u_blue (
    .pclk(pclk),
    .presetn(presetn),
    .reset_lit(1'b1),
    .qidx(qidx_ff),
    .qcnt(qcnt_ff),
    .pattern(blue_pat),
    .lit(blue_lit)
  );

  mhs_blink #(.QUARTER(BLINK_QUARTER)) u_red (
    .pclk(pclk),
    .presetn(presetn),
    .reset_lit(1'b1),
    .qidx(qidx_ff),
    .qcnt(qcnt_ff),
    .pattern(red_pat),
    .lit(red_lit)
  );

  // Red stays lit through reset and until the first clock edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) red_up_ff <= 1'b0;
    else red_up_ff <= 1'b1;
  end

  assign amber = ctrl_ff.health_error | ~payload_power_en | ctrl_ff.payload_reset;

  always_comb begin
    leds.blue = blue_lit;
    if (!red_up_ff) leds.red = 1'b1;
    else if (ctrl_ff.red_ovr_en) leds.red = ctrl_ff.red_ovr_on;
    else leds.red = red_lit;
    if (ctrl_ff.health_ovr_en) leds.amber = ctrl_ff.health_ovr_amber;
    else leds.amber = amber;
    leds.green = ~leds.amber;
  end

  // ************************************************************
  // Checks
  // ************************************************************
  handle_open_a: assert property (@(posedge pclk) disable iff (!por_n || !presetn)
    hs_ff == mhs_pkg::state_active && boot_ok && open_edge
    |=> handle_open_evt && hs_ff == mhs_pkg::state_deactivation_request)
    else $error("handle opening not reported");
  repeat_open_a: assert property (@(posedge pclk) disable iff (!por_n)
    hs_ff == mhs_pkg::state_deactivation_request |=> !handle_open_evt)
    else $error("repeated handle-open reported");
  quiesce_order_a: assert property (@(posedge pclk) disable iff (!por_n)
    quiesced_evt |-> !payload_power_en && !$past(payload_power_en, 2)
      && hs_ff == mhs_pkg::state_inactive)
    else $error("quiesced sent before power removed");
  reject_return_a: assert property (@(posedge pclk) disable iff (!por_n || !presetn)
    hs_ff == mhs_pkg::state_deactivation_request && cmd_ff[mhs_pkg::CMD_REJECT]
    |=> hs_ff == mhs_pkg::state_active ##2 !leds.blue)
    else $error("reject did not restore active");
  blue_solid_a: assert property (@(posedge pclk) disable iff (!por_n || !presetn)
    hs_ff == mhs_pkg::state_inactive [*3] |-> leds.blue)
    else $error("blue not on while inactive");
  blue_off_a: assert property (@(posedge pclk) disable iff (!por_n || !presetn)
    hs_ff == mhs_pkg::state_active [*2] |-> !leds.blue)
    else $error("blue lit while active");
  boot_order_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(fit_report) |-> $past(boot_ff, 2) == mhs_pkg::boot_checksum)
    else $error("fitness report out of order");
  run_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    boot_ff == mhs_pkg::boot_report |-> $past(sum_ff) == mhs_pkg::SUM_GOOD)
    else $error("ran with a bad checksum");
  wdog_pace_a: assert property (@(posedge pclk) disable iff (!presetn)
    boot_ok && wdog_cnt_ff == 32'(WDOG_CYC - 1) |=> wdog_strobe != $past(wdog_strobe))
    else $error("watchdog strobe missed");
  health_a: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_ff.health_ovr_en && !payload_power_en |-> leds.amber && !leds.green)
    else $error("health not amber with power down");
endmodule // mhs_manager

// ==== rtl/mhs_pkg.sv ====
// Constants, types and layouts shared by the hot-swap and LED manager.
// Assumes a single 100 MHz pclk and an APB master with 32-bit data.
//
// Behaviour
// - Detect active-low handle opening as extraction request.
// - Report handle-open; carrier moves active to deactivation-request. Here the manager makes that move itself on the opening edge.
// - On quiesce: cut payload power, then report quiesced.
// - Rejection returns state to active, blue off.
// - Blue solid on while inactive.
// - Blue long blink, 90 percent, during activation.
// - Blue solid off while active.
// - Blue short blink, 10 percent, during deactivation.
// - Blue flashes while quiescing, steady once power off.
// - Blue lit when seated, off after activation.
// - Red solid on while controller in reset.
// - Red fast 50 percent blink during upgrade.
// - Red short blink when payload power denied.
// - Health green if good, amber on error/power down.
// - Red and health LEDs have application override.
// - Boot: self-test, checksum, then fitness report.
// - Run operational code only after good checksum.
// - Strobe watchdog; its restart keeps payload power.

package mhs_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int BLINK_PERIOD_MS = 1000;
  localparam int BLINK_QUARTERS = 4;
  localparam int BLINK_QUARTER_CYC = BLINK_PERIOD_MS * (1000000 / CLK_PERIOD_NS) / BLINK_QUARTERS;
  localparam int WDOG_INTERVAL_US = 100;
  localparam int WDOG_INTERVAL_CYC = WDOG_INTERVAL_US * 1000 / CLK_PERIOD_NS;
  localparam int PCT_FULL = 100;
  localparam int LONG_ON_PCT = 90;
  localparam int SHORT_ON_PCT = 10;
  localparam int FAST_ON_PCT = 50;
  localparam int CNT_W = 32;

  // ************************************************************
  // Code image checked at boot
  // ************************************************************
  localparam int CODE_WORDS = 16;
  localparam int CODE_AW = 4;
  localparam logic [31:0] SUM_GOOD = 32'h0000_0000;

  // ************************************************************
  // APB register map
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] CMD_OFS = 12'h004;
  localparam logic [11:0] STATUS_OFS = 12'h008;
  localparam logic [11:0] EVT_OFS = 12'h00C;
  localparam int CMD_ACTIVATE = 0;
  localparam int CMD_QUIESCE = 1;
  localparam int CMD_REJECT = 2;
  localparam int CMD_W = 3;
  localparam int EVT_HANDLE_OPEN = 0;
  localparam int EVT_QUIESCED = 1;
  localparam int EVT_W = 2;
  localparam int STS_HS_LSB = 0;
  localparam int STS_BOOT_LSB = 4;
  localparam int STS_PAYLOAD = 8;
  localparam int STS_HANDLE_OPEN = 9;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    state_inactive, state_activation_request, state_activation_progress,
    state_active, state_deactivation_request, state_deactivation_progress
  } mhs_hs_type;

  typedef enum logic [2:0] {
    boot_selftest, boot_checksum, boot_report, boot_run, boot_halt
  } mhs_boot_type;

  typedef enum logic [2:0] {pat_off, pat_on, pat_long, pat_short, pat_fast} mhs_pattern_type;

  // Control register, bit 0 is red_ovr_en
  typedef struct packed {
    logic payload_reset;
    logic health_error;
    logic power_denied;
    logic upgrade_active;
    logic health_ovr_amber;
    logic health_ovr_en;
    logic red_ovr_on;
    logic red_ovr_en;
  } mhs_ctrl_type;
  localparam int CTRL_W = $bits(mhs_ctrl_type);
  localparam mhs_ctrl_type CTRL_RESET = '0;

  typedef struct packed {
    logic blue;
    logic red;
    logic green;
    logic amber;
  } mhs_led_type;

endpackage

// ==== rtl/mhs_sync.sv ====
// Two-flop synchroniser for asynchronous level pins.
// Assumes inputs are slow levels; no pulse may be shorter than two cycles.
`timescale 1ns/1ns
module mhs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, low
  input wire logic [WIDTH-1:0] async_in, // Pin levels
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);
  logic [WIDTH-1:0] meta_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // mhs_sync
